// ==== pkg/irq_bank_defines.svh ====
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// Register offsets on the plain register port, one 16-bit register per address.
`define OFS_FLAG_FIVE 8'h00
`define OFS_EN_ZERO 8'h02
`define OFS_EN_ONE 8'h04
`define OFS_EN_TWO 8'h06
`define OFS_OTG_PRIO 8'h08
`define OFS_EVT_STATUS 8'h0a
`define OFS_EVT_MASK 8'h0c

// Implemented-bit masks; every bit outside a mask reads as zero.
`define MASK_FLAG_FIVE 16'h0040
`define MASK_EN_ZERO 16'h3fef
`define MASK_EN_ONE 16'hfe1f
`define MASK_EN_TWO 16'h22e3
`define MASK_OTG_PRIO 16'h0007
`define MASK_EVT 16'h0003

// Field positions.
`define POS_OTG_FLAG 6
`define POS_EVT_OTG 0
`define POS_EVT_BAD 1

// Reset values.
`define RST_FLAG_FIVE 16'h0000
`define RST_EN 16'h0000
`define RST_PRIO 3'h4
`define PRIO_OFF 3'h0

`endif

// ==== pkg/irq_bank_pkg.sv ====
package irq_bank_pkg;

  // Plain register port request, sampled on the rising clock edge.
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Layout of enable_control_zero; also the layout of the matching request lines.
  typedef struct packed {
    logic [1:0] unused_15_14;
    logic converter_done_irq_en;
    logic serial1_tx_irq_en;
    logic serial1_rx_irq_en;
    logic sync1_done_irq_en;
    logic sync1_fault_irq_en;
    logic timer_three_irq_en;
    logic timer_two_irq_en;
    logic compare2_irq_en;
    logic capture2_irq_en;
    logic unused_4;
    logic timer_one_irq_en;
    logic compare1_irq_en;
    logic capture1_irq_en;
    logic ext_pin0_irq_en;
  } en_zero_s;

  // Layout of enable_control_one.
  typedef struct packed {
    logic serial2_tx_irq_en;
    logic serial2_rx_irq_en;
    logic ext_pin2_irq_en;
    logic timer_five_irq_en;
    logic timer_four_irq_en;
    logic compare4_irq_en;
    logic compare3_irq_en;
    logic [3:0] unused_8_5;
    logic ext_pin1_irq_en;
    logic change_notify_irq_en;
    logic comparator_irq_en;
    logic twowire1_master_irq_en;
    logic twowire1_slave_irq_en;
  } en_one_s;

  // Layout of enable_control_two.
  typedef struct packed {
    logic [1:0] unused_15_14;
    logic parallel_port_irq_en;
    logic [2:0] unused_12_10;
    logic compare5_irq_en;
    logic unused_8;
    logic capture5_irq_en;
    logic capture4_irq_en;
    logic capture3_irq_en;
    logic [2:0] unused_4_2;
    logic sync2_event_irq_en;
    logic sync2_fault_irq_en;
  } en_two_s;

  // One bit per gated source, grouped as the three enable registers.
  typedef struct packed {
    en_zero_s w0;
    en_one_s w1;
    en_two_s w2;
  } src_group_s;

endpackage

// ==== src/sticky_bits.sv ====
`timescale 1ns/1ps

// Bank of sticky bits: a set pulse holds the bit until a clear removes it.
// A set in the same cycle as a clear wins, so no event is ever lost.
module sticky_bits #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] bits
);

  // Clear first, then set on top of it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bits <= '0;
    end else begin
      bits <= (bits & ~clr) | set;
    end
  end

endmodule

// ==== src/prio_field.sv ====
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

// One three-bit priority field with its forwarding gate.
// Level 7 is the highest, level 1 the lowest, and level 0 turns the source off.
module prio_field (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic [2:0] wdata,
  input wire logic req,
  output logic [2:0] level,
  output logic pass
);

  // The field comes out of reset at the middle level.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= `RST_PRIO;
    end else if (wr) begin
      level <= wdata;
    end
  end

  // A source set to level 0 never reaches the priority logic.
  assign pass = req && (level != `PRIO_OFF);

endmodule

// ==== src/irq_flag_enable_bank.sv ====
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

// Summary of operation
// - Bit 6 of flag five records otg request.
// - Other flag five bits read zero, ignore writes.
// - Enable bits read/write; one passes, zero blocks.
// - All flag and enable bits reset to zero.
// - Unimplemented bits always read back as zero.
// - Enable zero bits 13-8: converter, serial1, sync1, timer3.
// - Enable zero bits 7-5, 3-0; bit 4 zero.
// - Enable one bits 15-9 map serial2 to compare3.
// - Enable one bits 4-0: pin1, notify, comparator, twowire.
// - Enable two bit 13 parallel, bit 9 compare5.
// - Enable two bits 7-5 capture, 1-0 sync2.
// - Three-bit priority, zero disables, reset value four.
module irq_flag_enable_bank (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire irq_bank_pkg::reg_req_s bus,
  output logic [15:0] rdata,
  input wire logic otg_req,
  input wire logic otg_enable,
  input wire irq_bank_pkg::src_group_s src_flags,
  output irq_bank_pkg::src_group_s fwd,
  output logic otg_fwd,
  output logic [2:0] otg_fwd_prio,
  output logic irq
);

  // Enable registers, held in their documented layouts.
  irq_bank_pkg::en_zero_s enable_control_zero;
  irq_bank_pkg::en_one_s enable_control_one;
  irq_bank_pkg::en_two_s enable_control_two;

  // Flag register five, kept as its one live bit.
  logic otg_irq_flag;

  // Event status and mask for the local interrupt output.
  logic [1:0] evt_status;
  logic [1:0] evt_mask;

  // Priority level of the otg source and its gate output.
  logic [2:0] otg_prio;
  logic otg_prio_pass;

  // Address decode; each register answers on exactly one address.
  wire hit_flag = (bus.addr == `OFS_FLAG_FIVE);
  wire hit_en0 = (bus.addr == `OFS_EN_ZERO);
  wire hit_en1 = (bus.addr == `OFS_EN_ONE);
  wire hit_en2 = (bus.addr == `OFS_EN_TWO);
  wire hit_prio = (bus.addr == `OFS_OTG_PRIO);
  wire hit_status = (bus.addr == `OFS_EVT_STATUS);
  wire hit_mask = (bus.addr == `OFS_EVT_MASK);
  wire hit_any = hit_flag | hit_en0 | hit_en1 | hit_en2 | hit_prio | hit_status | hit_mask;

  // Write strobes per register.
  wire wr_flag = bus.wr && hit_flag;
  wire wr_en0 = bus.wr && hit_en0;
  wire wr_en1 = bus.wr && hit_en1;
  wire wr_en2 = bus.wr && hit_en2;
  wire wr_prio = bus.wr && hit_prio;
  wire wr_status = bus.wr && hit_status;
  wire wr_mask = bus.wr && hit_mask;

  // An access to an address that holds no register is reported as an event.
  // Software gets zero on such a read, so the event is the only way to see it.
  wire bad_access = (bus.wr || bus.rd) && !hit_any;

  // Write data trimmed to the implemented bits of each register.
  wire [15:0] wdata_en0 = bus.wdata & `MASK_EN_ZERO;
  wire [15:0] wdata_en1 = bus.wdata & `MASK_EN_ONE;
  wire [15:0] wdata_en2 = bus.wdata & `MASK_EN_TWO;

  // Software may set or clear the flag; the source can only set it.
  wire flag_sw_set = wr_flag && bus.wdata[`POS_OTG_FLAG];
  wire flag_sw_clr = wr_flag && !bus.wdata[`POS_OTG_FLAG];
  wire flag_set = otg_req || flag_sw_set;

  // Event sources for the status register.
  wire [1:0] evt_set = {bad_access, otg_req};
  wire [1:0] evt_clr = wr_status ? bus.wdata[1:0] : 2'h0;

  // Read value of each register, with unimplemented bits forced low.
  wire [15:0] rd_flag = {9'h000, otg_irq_flag, 6'h00};
  wire [15:0] rd_en0 = enable_control_zero & `MASK_EN_ZERO;
  wire [15:0] rd_en1 = enable_control_one & `MASK_EN_ONE;
  wire [15:0] rd_en2 = enable_control_two & `MASK_EN_TWO;
  wire [15:0] rd_prio = {13'h0000, otg_prio};
  wire [15:0] rd_status = {14'h0000, evt_status};
  wire [15:0] rd_mask = {14'h0000, evt_mask};

  // Read multiplexer; an unmapped address yields zero.
  wire [15:0] rd_sel = hit_flag ? rd_flag :
                       hit_en0 ? rd_en0 :
                       hit_en1 ? rd_en1 :
                       hit_en2 ? rd_en2 :
                       hit_prio ? rd_prio :
                       hit_status ? rd_status :
                       hit_mask ? rd_mask : 16'h0000;

  // Gating of each request by its enable bit.
  // Reserved positions are masked so a stray request line there never leaks.
  wire [15:0] next_fwd_w0 = src_flags.w0 & enable_control_zero & `MASK_EN_ZERO;
  wire [15:0] next_fwd_w1 = src_flags.w1 & enable_control_one & `MASK_EN_ONE;
  wire [15:0] next_fwd_w2 = src_flags.w2 & enable_control_two & `MASK_EN_TWO;

  // The otg request needs its flag, its enable and a nonzero level.
  wire next_otg_fwd = otg_irq_flag && otg_enable && otg_prio_pass;

  // Level interrupt term before the output register.
  wire next_irq = |(evt_status & evt_mask);

  // Flag register five: only the otg bit exists.
  sticky_bits #(
    .WIDTH(1)
  ) u_otg_flag (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set(flag_set),
    .clr(flag_sw_clr),
    .bits(otg_irq_flag)
  );

  // Event status bits, cleared by writing a one.
  sticky_bits #(
    .WIDTH(2)
  ) u_evt_status (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set(evt_set),
    .clr(evt_clr),
    .bits(evt_status)
  );

  // Priority field of the otg source.
  prio_field u_otg_prio (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr(wr_prio),
    .wdata(bus.wdata[2:0]),
    .req(otg_irq_flag),
    .level(otg_prio),
    .pass(otg_prio_pass)
  );

  // Enable zero: converter, serial1, sync1 and timers one to three.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_control_zero <= `RST_EN;
    end else if (wr_en0) begin
      enable_control_zero <= wdata_en0;
    end
  end

  // Enable one: serial2, timers four and five, pins, notify, comparator, two-wire.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_control_one <= `RST_EN;
    end else if (wr_en1) begin
      enable_control_one <= wdata_en1;
    end
  end

  // Enable two: parallel port, compare5, captures three to five, sync2.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_control_two <= `RST_EN;
    end else if (wr_en2) begin
      enable_control_two <= wdata_en2;
    end
  end

  // Event mask; a one lets the matching status bit drive the interrupt.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_mask <= 2'h0;
    end else if (wr_mask) begin
      evt_mask <= bus.wdata[1:0];
    end
  end

  // Read data stands for one cycle after the read strobe and is zero otherwise.
  // Holding zero outside that cycle makes a missed strobe easy to spot.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      rdata <= rd_sel;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Forwarded requests are registered so every output leaves a flip-flop.
  // This costs one cycle of latency toward the priority logic.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd <= '0;
      otg_fwd <= 1'b0;
      otg_fwd_prio <= 3'h0;
    end else begin
      fwd <= {next_fwd_w0, next_fwd_w1, next_fwd_w2};
      otg_fwd <= next_otg_fwd;
      otg_fwd_prio <= next_otg_fwd ? otg_prio : 3'h0;
    end
  end

  // Interrupt output, high while any unmasked status bit is set.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Checks on the register file and the forwarding path.
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!rst_b);

  // A write to an enable register followed by a read of it.
  sequence s_write_en0;
    bus.wr && hit_en0;
  endsequence

  sequence s_read_en0;
    bus.rd && hit_en0 && !bus.wr;
  endsequence

  // The same write and read steps for the other two enable registers.
  sequence s_write_en1;
    bus.wr && hit_en1;
  endsequence

  sequence s_read_en1;
    bus.rd && hit_en1 && !bus.wr;
  endsequence

  sequence s_write_en2;
    bus.wr && hit_en2;
  endsequence

  sequence s_read_en2;
    bus.rd && hit_en2 && !bus.wr;
  endsequence

  // A source request with a software clear in the same cycle.
  sequence s_set_vs_clear;
    otg_req && flag_sw_clr;
  endsequence

  // Writing enable zero and reading it back returns the masked value.
  a_en0_readback: assert property (
    s_write_en0 ##1 s_read_en0 |=> rdata == ($past(bus.wdata, 2) & `MASK_EN_ZERO))
    else $error("enable zero read back wrong");

  // Flag five read never shows a bit other than bit six.
  a_flag_reserved_zero: assert property (
    $past(bus.rd) && $past(hit_flag) |-> (rdata & ~`MASK_FLAG_FIVE) == 16'h0000)
    else $error("flag five reserved bit read nonzero");

  // Enable one and two reads keep their unimplemented bits at zero.
  a_en_reserved_zero: assert property (
    $past(bus.rd) && ($past(hit_en1) || $past(hit_en2)) |->
      (rdata & ~($past(hit_en1) ? `MASK_EN_ONE : `MASK_EN_TWO)) == 16'h0000)
    else $error("enable reserved bit read nonzero");

  // A source request shows in the flag one cycle later.
  a_otg_flag_set: assert property (
    otg_req |=> otg_irq_flag)
    else $error("otg request did not set the flag");

  // The request beats a software clear in the same cycle.
  a_set_beats_clear: assert property (
    s_set_vs_clear |=> otg_irq_flag ##1 (otg_irq_flag || $past(flag_sw_clr)))
    else $error("flag lost on simultaneous clear");

  // Forwarded requests equal the flags gated by the enables one cycle before.
  a_fwd_gating: assert property (
    fwd.w0 == ($past(src_flags.w0) & $past(enable_control_zero))
      && fwd.w1 == ($past(src_flags.w1) & $past(enable_control_one))
      && fwd.w2 == ($past(src_flags.w2) & $past(enable_control_two)))
    else $error("forwarded request not gated by enable");

  // The otg request is forwarded only with flag, enable and a live level.
  a_otg_fwd_gate: assert property (
    otg_fwd |-> $past(otg_irq_flag) && $past(otg_enable) && $past(otg_prio) != 3'h0)
    else $error("otg forwarded without flag, enable or level");

  // A priority write is taken whole on the next cycle.
  a_prio_write: assert property (
    wr_prio |=> otg_prio == $past(bus.wdata[2:0]))
    else $error("priority field did not take the write");

  // The interrupt follows masked status with one cycle of delay.
  a_irq_level: assert property (
    irq == |($past(evt_status) & $past(evt_mask)))
    else $error("interrupt output does not follow masked status");

  // Writing enable one and reading it back returns the masked value.
  a_en1_readback: assert property (
    s_write_en1 ##1 s_read_en1 |=> rdata == ($past(bus.wdata, 2) & `MASK_EN_ONE))
    else $error("enable one read back wrong");

  // Writing enable two and reading it back returns the masked value.
  a_en2_readback: assert property (
    s_write_en2 ##1 s_read_en2 |=> rdata == ($past(bus.wdata, 2) & `MASK_EN_TWO))
    else $error("enable two read back wrong");

  // Read data stand only in the cycle after a read strobe.
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");

  // A read of a hole in the map returns zero.
  a_unmapped_zero: assert property (
    $past(bus.rd) && !$past(hit_any) |-> rdata == 16'h0000)
    else $error("unmapped read returned data");

  // Enable zero reads keep bits 15, 14 and 4 at zero.
  a_en0_reserved_zero: assert property (
    $past(bus.rd) && $past(hit_en0) |-> (rdata & ~`MASK_EN_ZERO) == 16'h0000)
    else $error("enable zero reserved bit read nonzero");

  // A software clear with no request in that cycle empties the flag.
  a_flag_sw_clear: assert property (
    flag_sw_clr && !otg_req |=> !otg_irq_flag)
    else $error("flag not cleared by software");

  // Every qualified otg request is forwarded on the next cycle.
  a_otg_fwd_taken: assert property (
    otg_irq_flag && otg_enable && otg_prio != 3'h0 |=> otg_fwd)
    else $error("qualified otg request not forwarded");

  // The forwarded level is the programmed one, and zero when nothing is forwarded.
  a_fwd_level: assert property (
    otg_fwd_prio == (otg_fwd ? $past(otg_prio) : 3'h0))
    else $error("forwarded level does not match the field");

  // An access to a hole in the map raises the bad-address event.
  a_bad_access_event: assert property (
    bad_access |=> evt_status[`POS_EVT_BAD])
    else $error("bad access did not raise its event");

  // Writing a one to a status bit clears it unless its event recurs.
  a_status_clear: assert property (
    wr_status && bus.wdata[`POS_EVT_OTG] && !otg_req |=> !evt_status[`POS_EVT_OTG])
    else $error("status bit not cleared by a written one");

endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

// Self-checking bench for the flag and enable bank; it drives every port itself.
module tb_top;
  logic ref_clk;
  logic rst_b;
  irq_bank_pkg::reg_req_s bus;
  logic [15:0] rdata;
  logic otg_req;
  logic otg_enable;
  irq_bank_pkg::src_group_s src_flags;
  irq_bank_pkg::src_group_s fwd;
  logic otg_fwd;
  logic [2:0] otg_fwd_prio;
  logic irq;
  // A read strobe seen at the last edge, so its data stand now.
  logic rd_d = 1'b0;
  // Generator state; it starts at 8097.
  logic [31:0] seed = 32'h00001fa1;
  logic [63:0] r;
  logic [15:0] d;
  int n_mismatch = 0;
  int check_count = 0;
  // Expected read data and expected output snapshots, oldest first.
  logic [15:0] rd_q[$];
  logic [52:0] out_q[$];
  // Implemented bits of the three enable registers, worked out bit by bit.
  logic [15:0] en_mask [0:2] = '{16'h3fef, 16'hfe1f, 16'h22e3};
  logic [15:0] en_val [0:2];

  irq_flag_enable_bank dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bus(bus),
    .rdata(rdata),
    .otg_req(otg_req),
    .otg_enable(otg_enable),
    .src_flags(src_flags),
    .fwd(fwd),
    .otg_fwd(otg_fwd),
    .otg_fwd_prio(otg_fwd_prio),
    .irq(irq)
  );

  // Free-running 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Xorshift generator, so every run sees the same values.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [52:0] got, input logic [52:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected outputs at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    // A note that was never judged means an expected result never showed.
    if (rd_q.size() != 0 || out_q.size() != 0) begin
      n_mismatch++;
      $display("unexpected notes left at %0t: got %h expected %h", $time,
               rd_q.size() + out_q.size(), 32'h00000000);
    end
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Each access ends by idling the bus, so the next one starts a fresh edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    rd_q.push_back(e);
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // Write then read the same place with no gap between the strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    rd_q.push_back(e);
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic expect_out(input logic [47:0] f, input logic o, input logic [2:0] p,
                            input logic i);
    out_q.push_back({f, o, p, i});
  endtask

  // Remember each read strobe that the design took.
  always @(posedge ref_clk) begin
    rd_d <= bus.rd;
  end

  // Outputs are settled at the falling edge; the oldest notes are judged there.
  always @(negedge ref_clk) begin
    if (rd_d && rd_q.size() > 0) begin
      cmp_rd(rdata, rd_q.pop_front());
    end else if (!rd_d) begin
      cmp_rd(rdata, 16'h0000);
    end
    while (out_q.size() > 0) begin
      cmp_out({fwd, otg_fwd, otg_fwd_prio, irq}, out_q.pop_front());
    end
  end

  // Cuts a hang short well beyond the few hundred cycles the run needs.
  initial begin
    idle(3000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    bus = '0;
    otg_req = 1'b0;
    otg_enable = 1'b0;
    src_flags = '0;
    idle(20);
    expect_out('0, 1'b0, 3'h0, 1'b0);
    rst_b <= 1'b1;
    // Reset values of every mapped register; only the priority is not zero.
    for (int k = 0; k < 7; k++) begin
      rd(8'(2 * k), (k == 4) ? 16'h0004 : 16'h0000);
    end
    wr_rd(`OFS_FLAG_FIVE, 16'hffff, 16'h0040);
    wr_rd(`OFS_FLAG_FIVE, 16'hffbf, 16'h0000);
    // All ones, all zeros and random patterns through each enable register.
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 4; k++) begin
        d = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'(xs());
        en_val[i] = d & en_mask[i];
        wr_rd(8'(2 + 2 * i), d, en_val[i]);
      end
    end
    // Gating: the first pass raises every request with every enable off.
    for (int j = 0; j < 5; j++) begin
      r = (j == 0) ? '1 : {xs(), xs()};
      src_flags <= r[47:0];
      for (int i = 0; i < 3; i++) begin
        d = (j == 0) ? 16'h0000 : 16'(xs());
        en_val[i] = d & en_mask[i];
        wr(8'(2 + 2 * i), d);
      end
      idle(2);
      expect_out({en_val[0], en_val[1], en_val[2]} & r[47:0], 1'b0, 3'h0, 1'b0);
    end
    // External pin sources alone; the bench stands in for the routed pins.
    src_flags <= '1;
    wr(`OFS_EN_ZERO, 16'h0001);
    wr(`OFS_EN_ONE, 16'h2010);
    wr(`OFS_EN_TWO, 16'h0000);
    en_val = '{16'h0001, 16'h2010, 16'h0000};
    idle(2);
    expect_out({en_val[0], en_val[1], en_val[2]}, 1'b0, 3'h0, 1'b0);
    src_flags <= '0;
    wr_rd(`OFS_EVT_MASK, 16'hffff, 16'h0003);
    wr_rd(`OFS_OTG_PRIO, 16'hffff, 16'h0007);
    otg_enable <= 1'b1;
    @(posedge ref_clk);
    otg_req <= 1'b1;
    @(posedge ref_clk);
    otg_req <= 1'b0;
    idle(3);
    expect_out('0, 1'b1, 3'h7, 1'b1);
    rd(`OFS_FLAG_FIVE, 16'h0040);
    rd(`OFS_EVT_STATUS, 16'h0001);
    // A request in the same cycle as a software clear must win, for flag and status.
    @(posedge ref_clk);
    bus <= '{addr: `OFS_FLAG_FIVE, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    otg_req <= 1'b1;
    @(posedge ref_clk);
    bus <= '{addr: `OFS_EVT_STATUS, wdata: 16'h0001, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    otg_req <= 1'b0;
    rd(`OFS_FLAG_FIVE, 16'h0040);
    rd(`OFS_EVT_STATUS, 16'h0001);
    // Every priority level; level zero must stop forwarding.
    for (int p = 0; p < 8; p++) begin
      wr(`OFS_OTG_PRIO, 16'(p));
      idle(2);
      expect_out('0, p != 0, 3'(p), 1'b1);
    end
    otg_enable <= 1'b0;
    idle(2);
    expect_out('0, 1'b0, 3'h0, 1'b1);
    wr(`OFS_EVT_STATUS, 16'h0001);
    wr(`OFS_FLAG_FIVE, 16'h0000);
    idle(2);
    expect_out('0, 1'b0, 3'h0, 1'b0);
    // Unmapped places read zero and ignore writes, but raise the event.
    rd(8'h0e, 16'h0000);
    wr(8'h20, 16'hffff);
    rd(`OFS_EN_ZERO, en_val[0]);
    rd(`OFS_EVT_STATUS, 16'h0002);
    expect_out('0, 1'b0, 3'h0, 1'b1);
    wr(`OFS_EVT_STATUS, 16'h0003);
    idle(2);
    expect_out('0, 1'b0, 3'h0, 1'b0);
    // A second reset in mid-run must clear the enables again.
    rst_b <= 1'b0;
    idle(2);
    expect_out('0, 1'b0, 3'h0, 1'b0);
    rst_b <= 1'b1;
    rd(`OFS_EN_ONE, 16'h0000);
    rd(`OFS_OTG_PRIO, 16'h0004);
    idle(2);
    finish_test();
  end
endmodule
